// ==== logic/ihc_host.sv ====
// What this block does
// - Ack go drives SCL low and puts the ack value on SDA.
// - Ack: wait a bit period, release SCL, wait high, bit period, SCL low.
// - Ack end clears ack go, stops counter, returns idle.
// - Buffer write during a sequence is dropped and sets write collision.
// - Stop go drives SDA low; once seen low, counter reloads and counts.
// - Stop timeout releases SCL, then SDA one bit period later.
// - SDA high with SCL high sets stop seen; later clear stop go, set irq.
// - Client portion keeps working in sleep and may wake via irq.
// - Reset disables the port and aborts any transfer.
// - Start seen and stop seen clear on reset or disable.
// - With irq enabled, a bus stop raises the serial irq.
// - Released SDA sampled low with SCL high sets collision, goes idle.
// - Collision in byte send halts shift, clears full, releases lines.
// - Collision in a sequence aborts it, releases lines, clears its go.
// - Buffer write after collision restarts from the first data bit.
// - Start aborts on lines low at start or SCL low with SDA high.
// - Start: early SDA fall restarts count; then SCL low at count end.
// - Restart: count, release SCL, sample SDA once high, low is collision.
// - Restart count: SDA fall fine; SCL fall before SDA driven is collision.
// - Restart timeout with both high drives SDA low, then SCL low.
// - Counter reloads twice per SCL period; reloads under three are clamped.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ihc_host (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire ihc_pkg::ihc_req_t          busReq,
  output logic [ihc_pkg::DATA_W-1:0]      rdData,
  input  wire logic                       sclIn,
  output logic                            sclOut,
  output logic                            sclOe,
  input  wire logic                       sdaIn,
  output logic                            sdaOut,
  output logic                            sdaOe,
  output logic                            portIrq
);
  ihc_pkg::ihc_state_t state_ff, nxt_state;
  logic [ihc_pkg::DATA_W-1:0] ctl_ff, nxt_ctl;
  logic [ihc_pkg::DATA_W-1:0] reload_ff;
  logic [ihc_pkg::DATA_W-1:0] shift_ff;
  logic [ihc_pkg::DATA_W-1:0] rdData_ff;
  logic [8:0]                 cnt_ff;
  logic [3:0]                 bitCnt_ff;
  logic sclS1_ff, sclS_ff, sdaS1_ff, sdaS_ff, sdaPrev_ff;
  logic sclLow_ff, nxt_sclLow, sdaLow_ff, nxt_sdaLow;
  logic full_ff, startSeen_ff, stopSeen_ff, spIrq_ff, bColl_ff, wColl_ff, ackStat_ff;
  logic irq_ff;
  logic cntLoad, seqDone, coll, txDone, ackSample;
  // Sampled bus lines, two flops each, plus a delayed SDA copy for edge detection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclS1_ff   <= 1'b1;
      sclS_ff    <= 1'b1;
      sdaS1_ff   <= 1'b1;
      sdaS_ff    <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end
    else
    begin
      sclS1_ff   <= sclIn;
      sclS_ff    <= sclS1_ff;
      sdaS1_ff   <= sdaIn;
      sdaS_ff    <= sdaS1_ff;
      sdaPrev_ff <= sdaS_ff;
    end
  end
  wire portEn   = ctl_ff[ihc_pkg::CTL_ENABLE];
  wire ackVal   = ctl_ff[ihc_pkg::CTL_ACKVAL];
  wire idle     = (state_ff == ihc_pkg::IDLE);
  wire tick     = (cnt_ff == 9'h000);
  wire busStart = sclS_ff && sdaPrev_ff && !sdaS_ff;
  wire busStop  = sclS_ff && !sdaPrev_ff && sdaS_ff;
  wire wrCtl    = busReq.wr && (busReq.addr == ihc_pkg::HOST_CONTROL_REG);
  wire wrStat   = busReq.wr && (busReq.addr == ihc_pkg::PORT_STATUS_REG);
  wire wrRel    = busReq.wr && (busReq.addr == ihc_pkg::BIT_RATE_RELOAD_REG);
  wire wrBuf    = busReq.wr && (busReq.addr == ihc_pkg::SHIFT_BUFFER_REG);
  wire bufTake  = wrBuf && idle && portEn;
  wire bufRefuse = wrBuf && !(idle && portEn);
  wire [ihc_pkg::DATA_W-1:0] relEff = (reload_ff < ihc_pkg::RELOAD_MIN) ? ihc_pkg::RELOAD_MIN : reload_ff;
  // Two loads per SCL period, each worth two clocks per reload step
  wire [8:0] cntInit = {relEff, 1'b1};
  wire txBit    = (bitCnt_ff == ihc_pkg::LAST_BIT) ? 1'b1 : shift_ff[ihc_pkg::DATA_W-1];
  wire [ihc_pkg::DATA_W-1:0] goMask = 8'h0f;
  wire goAny    = |(ctl_ff & goMask);
  // Sequence engine
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_sclLow = sclLow_ff;
    nxt_sdaLow = sdaLow_ff;
    cntLoad    = 1'b0;
    seqDone    = 1'b0;
    coll       = 1'b0;
    txDone     = 1'b0;
    ackSample  = 1'b0;
    unique case (state_ff)
      ihc_pkg::IDLE:
      begin
        if (bufTake)
        begin
          nxt_state  = ihc_pkg::TX_LOW;
          nxt_sclLow = 1'b1;
          cntLoad    = 1'b1;
        end
        else if (portEn && ctl_ff[ihc_pkg::CTL_START])
        begin
          if (!sdaS_ff || !sclS_ff)
            coll = 1'b1;
          else
          begin
            nxt_state = ihc_pkg::ST_CNT1;
            cntLoad   = 1'b1;
          end
        end
        else if (portEn && ctl_ff[ihc_pkg::CTL_RESTART])
        begin
          nxt_state  = ihc_pkg::RS_CNT1;
          nxt_sdaLow = 1'b0;
          cntLoad    = 1'b1;
        end
        else if (portEn && ctl_ff[ihc_pkg::CTL_STOP])
        begin
          nxt_state  = ihc_pkg::SP_SDAL;
          nxt_sdaLow = 1'b1;
          cntLoad    = 1'b1;
        end
        else if (portEn && ctl_ff[ihc_pkg::CTL_ACK])
        begin
          nxt_state  = ihc_pkg::AK_LOW;
          nxt_sclLow = 1'b1;
          nxt_sdaLow = !ackVal;
          cntLoad    = 1'b1;
        end
      end
      ihc_pkg::ST_CNT1:
      begin
        if (!sclS_ff && sdaS_ff)
          coll = 1'b1;
        else if (!sdaS_ff || tick)
        begin
          nxt_state  = ihc_pkg::ST_CNT2;
          nxt_sdaLow = 1'b1;
          cntLoad    = 1'b1;
        end
      end
      ihc_pkg::ST_CNT2:
      begin
        if (tick)
        begin
          nxt_sclLow = 1'b1;
          seqDone    = 1'b1;
        end
      end
      ihc_pkg::RS_CNT1:
      begin
        if (sdaS_ff && tick)
        begin
          nxt_state  = ihc_pkg::RS_SCLH;
          nxt_sclLow = 1'b0;
        end
      end
      ihc_pkg::RS_SCLH:
      begin
        if (sclS_ff && !sdaS_ff)
          coll = 1'b1;
        else if (sclS_ff)
        begin
          nxt_state = ihc_pkg::RS_CNT2;
          cntLoad   = 1'b1;
        end
      end
      ihc_pkg::RS_CNT2:
      begin
        // A foreign SDA fall here is tolerated, a foreign SCL fall is not
        if (!sclS_ff)
          coll = 1'b1;
        else if (tick)
        begin
          nxt_state  = ihc_pkg::RS_CNT3;
          nxt_sdaLow = 1'b1;
          cntLoad    = 1'b1;
        end
      end
      ihc_pkg::RS_CNT3:
      begin
        if (tick)
        begin
          nxt_sclLow = 1'b1;
          seqDone    = 1'b1;
        end
      end
      ihc_pkg::SP_SDAL:
      begin
        if (sdaS_ff)
          cntLoad = 1'b1;
        else if (tick)
        begin
          nxt_state  = ihc_pkg::SP_SCLH;
          nxt_sclLow = 1'b0;
          cntLoad    = 1'b1;
        end
      end
      ihc_pkg::SP_SCLH:
      begin
        if (!sclS_ff)
          cntLoad = 1'b1;
        else if (tick)
        begin
          nxt_state  = ihc_pkg::SP_SDAH;
          nxt_sdaLow = 1'b0;
          cntLoad    = 1'b1;
        end
      end
      ihc_pkg::SP_SDAH:
      begin
        if (sdaS_ff && sclS_ff)
        begin
          nxt_state = ihc_pkg::SP_WAIT;
          cntLoad   = 1'b1;
        end
        else if (tick)
          coll = 1'b1;
      end
      ihc_pkg::SP_WAIT:
      begin
        if (tick)
          seqDone = 1'b1;
      end
      ihc_pkg::AK_LOW:
      begin
        if (tick)
        begin
          nxt_state  = ihc_pkg::AK_SCLH;
          nxt_sclLow = 1'b0;
          cntLoad    = 1'b1;
        end
      end
      ihc_pkg::AK_SCLH:
      begin
        if (!sclS_ff)
          cntLoad = 1'b1;
        else if (ackVal && !sdaS_ff)
          coll = 1'b1;
        else if (tick)
        begin
          nxt_sclLow = 1'b1;
          seqDone    = 1'b1;
        end
      end
      ihc_pkg::TX_LOW:
      begin
        nxt_sdaLow = !txBit;
        if (tick)
        begin
          nxt_state  = ihc_pkg::TX_HIGH;
          nxt_sclLow = 1'b0;
          cntLoad    = 1'b1;
        end
      end
      ihc_pkg::TX_HIGH:
      begin
        if (!sclS_ff)
          cntLoad = 1'b1;
        else if ((bitCnt_ff != ihc_pkg::LAST_BIT) && txBit && !sdaS_ff)
          coll = 1'b1;
        else if (tick)
        begin
          nxt_sclLow = 1'b1;
          ackSample  = (bitCnt_ff == ihc_pkg::LAST_BIT);
          if (bitCnt_ff == ihc_pkg::LAST_BIT)
          begin
            nxt_state  = ihc_pkg::IDLE;
            nxt_sdaLow = 1'b0;
            txDone     = 1'b1;
          end
          else
          begin
            nxt_state = ihc_pkg::TX_LOW;
            cntLoad   = 1'b1;
          end
        end
      end
      default:
        coll = 1'b1;
    endcase
    if (seqDone)
      nxt_state = ihc_pkg::IDLE;
    if (coll)
    begin
      nxt_state  = ihc_pkg::IDLE;
      nxt_sclLow = 1'b0;
      nxt_sdaLow = 1'b0;
    end
    if (!portEn)
    begin
      nxt_state  = ihc_pkg::IDLE;
      nxt_sclLow = 1'b0;
      nxt_sdaLow = 1'b0;
    end
  end
  // Go bits: software sets them only while idle, hardware clears on end or collision
  always_comb
  begin
    nxt_ctl = ctl_ff;
    if (wrCtl)
    begin
      nxt_ctl[ihc_pkg::DATA_W-1:4] = busReq.wdata[ihc_pkg::DATA_W-1:4];
      if (idle && !goAny)
        nxt_ctl[3:0] = busReq.wdata[3:0];
    end
    if (seqDone || coll)
      nxt_ctl[3:0] = 4'h0;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff  <= ihc_pkg::IDLE;
      ctl_ff    <= 8'h00;
      sclLow_ff <= 1'b0;
      sdaLow_ff <= 1'b0;
      cnt_ff    <= 9'h000;
    end
    else
    begin
      state_ff  <= nxt_state;
      ctl_ff    <= nxt_ctl;
      sclLow_ff <= nxt_sclLow;
      sdaLow_ff <= nxt_sdaLow;
      // Counter parks at zero in idle
      cnt_ff    <= cntLoad ? cntInit : (tick ? 9'h000 : cnt_ff - 9'h001);
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_ff  <= 8'h00;
      bitCnt_ff <= 4'h0;
      reload_ff <= ihc_pkg::RELOAD_RST;
    end
    else
    begin
      if (wrRel)
        reload_ff <= busReq.wdata;
      if (bufTake)
      begin
        shift_ff  <= busReq.wdata;
        bitCnt_ff <= 4'h0;
      end
      else if (state_ff == ihc_pkg::TX_HIGH && sclS_ff && tick && !coll)
      begin
        shift_ff  <= {shift_ff[ihc_pkg::DATA_W-2:0], 1'b0};
        bitCnt_ff <= bitCnt_ff + 4'h1;
      end
    end
  end
  // Status flags; a hardware set beats a same-cycle software clear
  wire clrSp = wrStat && busReq.wdata[ihc_pkg::ST_SPIRQ];
  wire clrBc = wrStat && busReq.wdata[ihc_pkg::ST_BCOLL];
  wire clrWc = wrStat && busReq.wdata[ihc_pkg::ST_WCOLL];
  wire setSp = seqDone || txDone || (busStop && ctl_ff[ihc_pkg::CTL_IRQEN]);
  wire emptyNow = (state_ff == ihc_pkg::TX_HIGH) && (bitCnt_ff == 4'h7) && tick && sclS_ff;
  wire [ihc_pkg::DATA_W-1:0] statWord = {1'b0, ackStat_ff, wColl_ff, bColl_ff, spIrq_ff,
                                         stopSeen_ff, startSeen_ff, full_ff};
  wire [ihc_pkg::DATA_W-1:0] rdMux =
    (busReq.addr == ihc_pkg::HOST_CONTROL_REG)    ? ctl_ff :
    (busReq.addr == ihc_pkg::PORT_STATUS_REG)     ? statWord :
    (busReq.addr == ihc_pkg::BIT_RATE_RELOAD_REG) ? reload_ff :
    (busReq.addr == ihc_pkg::SHIFT_BUFFER_REG)    ? shift_ff : 8'h00;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      full_ff      <= 1'b0;
      startSeen_ff <= 1'b0;
      stopSeen_ff  <= 1'b0;
      spIrq_ff     <= 1'b0;
      bColl_ff     <= 1'b0;
      wColl_ff     <= 1'b0;
      ackStat_ff   <= 1'b0;
      irq_ff       <= 1'b0;
      rdData_ff    <= 8'h00;
    end
    else
    begin
      full_ff      <= bufTake || (full_ff && !coll && !emptyNow && portEn);
      startSeen_ff <= portEn && (busStart || (startSeen_ff && !busStop));
      stopSeen_ff  <= portEn && (busStop || (stopSeen_ff && !busStart));
      spIrq_ff     <= setSp || (spIrq_ff && !clrSp);
      bColl_ff     <= coll || (bColl_ff && !clrBc);
      wColl_ff     <= bufRefuse || (wColl_ff && !clrWc);
      ackStat_ff   <= ackSample ? sdaS_ff : ackStat_ff;
      // Irq stays usable in sleep since the core clock keeps running
      irq_ff       <= ctl_ff[ihc_pkg::CTL_IRQEN] && (setSp || spIrq_ff || coll || bColl_ff);
      rdData_ff    <= busReq.rd ? rdMux : 8'h00;
    end
  end
  assign rdData  = rdData_ff;
  assign sclOut  = 1'b0;
  assign sdaOut  = 1'b0;
  assign sclOe   = sclLow_ff;
  assign sdaOe   = sdaLow_ff;
  assign portIrq = irq_ff;
  a_open_drain: assert property (@(posedge clk) disable iff (!rst_b) !sclOut && !sdaOut)
    else $error("line driven high");
  a_write_collision_flag_busy: assert property (@(posedge clk) disable iff (!rst_b)
    (wrBuf && !idle && (state_ff != ihc_pkg::TX_HIGH)) |=> (wColl_ff && $stable(shift_ff)))
    else $error("busy buffer write not refused");
  a_ack_present: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ihc_pkg::AK_LOW) |-> (sclLow_ff && (sdaLow_ff == !ackVal)))
    else $error("ack value not on bus");
  a_ack_finish: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ihc_pkg::AK_SCLH && seqDone) |=> (idle && !ctl_ff[ihc_pkg::CTL_ACK] && sclLow_ff && tick))
    else $error("ack end wrong");
  a_coll_release: assert property (@(posedge clk) disable iff (!rst_b)
    coll |=> (idle && !sclOe && !sdaOe && bColl_ff && (ctl_ff[3:0] == 4'h0) && !full_ff))
    else $error("collision not handled");
  a_start_abort: assert property (@(posedge clk) disable iff (!rst_b)
    (portEn && state_ff == ihc_pkg::ST_CNT1 && !sclS_ff && sdaS_ff) |=> (bColl_ff && idle))
    else $error("start collision missed");
  a_flags_disabled: assert property (@(posedge clk) disable iff (!rst_b)
    !portEn |=> (!startSeen_ff && !stopSeen_ff && idle))
    else $error("seen flags kept while disabled");
  a_stop_finish: assert property (@(posedge clk) disable iff (!rst_b)
    (portEn && state_ff == ihc_pkg::SP_WAIT && tick) |=> (spIrq_ff && !ctl_ff[ihc_pkg::CTL_STOP] && !sdaOe))
    else $error("stop end wrong");
  a_stop_seen: assert property (@(posedge clk) disable iff (!rst_b)
    (portEn && busStop) |=> stopSeen_ff ##0 (!startSeen_ff))
    else $error("bus stop not flagged");
  a_tx_restart: assert property (@(posedge clk) disable iff (!rst_b)
    bufTake |=> (bitCnt_ff == 4'h0 && full_ff && state_ff == ihc_pkg::TX_LOW))
    else $error("send not from first bit");
  c_ack_done:  cover property (@(posedge clk) state_ff == ihc_pkg::AK_SCLH && seqDone);
  c_stop_done: cover property (@(posedge clk) state_ff == ihc_pkg::SP_WAIT && seqDone);
  c_restart:   cover property (@(posedge clk) state_ff == ihc_pkg::RS_CNT3 && seqDone);
  c_tx_coll:   cover property (@(posedge clk) state_ff == ihc_pkg::TX_HIGH && coll);
endmodule
`default_nettype wire

// ==== logic/ihc_pkg.sv ====
`default_nettype none
package ihc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] HOST_CONTROL_REG  = 3'h0;
  localparam logic [ADDR_W-1:0] PORT_STATUS_REG   = 3'h1;
  localparam logic [ADDR_W-1:0] BIT_RATE_RELOAD_REG = 3'h2;
  localparam logic [ADDR_W-1:0] SHIFT_BUFFER_REG  = 3'h3;
  localparam int CTL_START   = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP    = 2;
  localparam int CTL_ACK     = 3;
  localparam int CTL_ACKVAL  = 4;
  localparam int CTL_ENABLE  = 5;
  localparam int CTL_IRQEN   = 6;
  localparam int ST_FULL     = 0;
  localparam int ST_STARTSEEN = 1;
  localparam int ST_STOPSEEN = 2;
  localparam int ST_SPIRQ    = 3;
  localparam int ST_BCOLL    = 4;
  localparam int ST_WCOLL    = 5;
  localparam int ST_ACKSTAT  = 6;
  localparam logic [DATA_W-1:0] RELOAD_RST = 8'h09;
  localparam logic [DATA_W-1:0] RELOAD_MIN = 8'h03;
  localparam logic [3:0] LAST_BIT = 4'h8;
  typedef enum logic [3:0] {
    IDLE    = 4'h0,
    ST_CNT1 = 4'h1,
    ST_CNT2 = 4'h2,
    RS_CNT1 = 4'h3,
    RS_SCLH = 4'h4,
    RS_CNT2 = 4'h5,
    RS_CNT3 = 4'h6,
    SP_SDAL = 4'h7,
    SP_SCLH = 4'h8,
    SP_SDAH = 4'h9,
    SP_WAIT = 4'ha,
    AK_LOW  = 4'hb,
    AK_SCLH = 4'hc,
    TX_LOW  = 4'hd,
    TX_HIGH = 4'he
  } ihc_state_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ihc_req_t;
endpackage
`default_nettype wire

// ==== verif/ihc_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ihc_bus_model #(
  parameter int STRETCH = 10
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic hostSclOe,
  input  wire logic hostSdaOe,
  input  wire logic pullScl,
  input  wire logic pullSda,
  input  wire logic stretchEn,
  output logic      sclWire,
  output logic      sdaWire
);
  logic [7:0] stretchCnt_ff;
  logic       prevSclOe_ff;
  wire logic  hostRelease = prevSclOe_ff && !hostSclOe;
  // Client holds SCL low a while after the host lets go
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stretchCnt_ff <= 8'h00;
      prevSclOe_ff  <= 1'b0;
    end
    else
    begin
      prevSclOe_ff <= hostSclOe;
      if (hostRelease && stretchEn)
        stretchCnt_ff <= 8'(STRETCH);
      else if (stretchCnt_ff != 8'h00)
        stretchCnt_ff <= stretchCnt_ff - 8'h01;
    end
  end
  // Pull-ups: a released line reads high, any party pulling wins
  // Stretch starts on the release itself, so SCL never shows a one-cycle high glitch
  assign sclWire = !(hostSclOe || pullScl || (stretchCnt_ff != 8'h00) || (hostRelease && stretchEn));
  assign sdaWire = !(hostSdaOe || pullSda);
endmodule
`default_nettype wire

// ==== verif/ihc_host_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module ihc_host_tb;
  localparam int H = 8;
  localparam int S = 10;
  localparam int WL = 80;
  localparam logic [2:0] CTL = ihc_pkg::HOST_CONTROL_REG;
  localparam logic [2:0] STS = ihc_pkg::PORT_STATUS_REG;
  localparam logic [2:0] RLD = ihc_pkg::BIT_RATE_RELOAD_REG;
  localparam logic [2:0] BUF = ihc_pkg::SHIFT_BUFFER_REG;
  logic               clk;
  logic               rst_b;
  ihc_pkg::ihc_req_t  req;
  logic [7:0]         rdData;
  logic               sclOe;
  logic               sdaOe;
  logic               sclWire;
  logic               sdaWire;
  logic               portIrq;
  logic               pullScl;
  logic               pullSda;
  logic               stretchEn;
  logic [7:0]         v;
  logic [7:0]         base;
  int                 n;
  int                 fail_count;
  int                 total_checks;

  ihc_host u_ihc_host (.clk(clk), .rst_b(rst_b), .busReq(req), .rdData(rdData), .sclIn(sclWire), .sclOut(),
    .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(), .sdaOe(sdaOe), .portIrq(portIrq));
  ihc_bus_model #(.STRETCH(S)) u_ihc_bus_model (.clk(clk), .rst_b(rst_b), .hostSclOe(sclOe), .hostSdaOe(sdaOe),
    .pullScl(pullScl), .pullSda(pullSda), .stretchEn(stretchEn), .sclWire(sclWire), .sdaWire(sdaWire));

  function automatic logic [7:0] b(input int i);
    return 8'h01 << i;
  endfunction

  task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic cb(input string w, input logic [7:0] word, input int p, input logic e);
    chk(w, 8'(word[p]), 8'(e));
  endtask

  task automatic cr(input string w, input int lo, input int hi);
    chk(w, 8'(n >= lo && n <= hi), 8'h01);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    v = rdData;
  endtask

  // Bounded wait on one of the host line enables
  task automatic wl(input bit sda, input logic lvl);
    n = 0;
    #1;
    while (((sda ? sdaOe : sclOe) !== lvl) && n < WL)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("waitLimit", 8'(n >= WL), 8'h00);
  endtask

  task automatic pulse_sda_at_scl_release();
    wl(1'b0, 1'b0);
    // SDA must already be low when the host first sees SCL high
    pullSda <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #(20000 * 100);
    fail_count++;
    close_out();
  end

  initial
  begin
    rst_b = 1'b0;
    req = '0;
    pullScl = 1'b0;
    pullSda = 1'b0;
    stretchEn = 1'b1;
    fail_count = 0;
    total_checks = 0;
    base = b(ihc_pkg::CTL_ENABLE) | b(ihc_pkg::CTL_IRQEN);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(CTL);
    chk("ctrlReset", v, 8'h00);
    rd(STS);
    chk("statusReset", v, 8'h00);
    rd(3'h7);
    chk("unmapped", v, 8'h00);
    wr(CTL, base);
    wr(RLD, 8'h03);
    rd(RLD);
    chk("reload", v, 8'h03);
    // Second pass uses a too-small reload, which must time like the minimum
    for (int i = 0; i < 2; i++)
    begin
      wr(RLD, (i == 1) ? 8'h01 : 8'h03);
      wr(CTL, base | b(ihc_pkg::CTL_ACK));
      repeat (2) @(posedge clk);
      #1;
      chk("ackScl", 8'(sclOe), 8'h01);
      chk("ackSda", 8'(sdaOe), 8'h01);
      wr(BUF, 8'h5a);
      wl(1'b0, 1'b0);
      cr("ackLow", H - 4, H + 1);
      wl(1'b0, 1'b1);
      cr("ackHigh", H + S, H + S + 4);
      repeat (2) @(posedge clk);
      rd(CTL);
      cb("ackGo", v, ihc_pkg::CTL_ACK, 1'b0);
      rd(STS);
      cb("ackIrq", v, ihc_pkg::ST_SPIRQ, 1'b1);
      cb("ackWcol", v, ihc_pkg::ST_WCOLL, 1'b1);
      wr(STS, 8'h38);
    end
    stretchEn <= 1'b0;
    wr(CTL, base | b(ihc_pkg::CTL_STOP));
    wl(1'b1, 1'b1);
    wr(BUF, 8'h5a);
    wl(1'b0, 1'b0);
    cr("stopScl", H - 2, H + 4);
    chk("stopSdaHeld", 8'(sdaOe), 8'h01);
    wl(1'b1, 1'b0);
    cr("stopSda", H, H + 4);
    repeat (H + 6) @(posedge clk);
    rd(CTL);
    cb("stopGo", v, ihc_pkg::CTL_STOP, 1'b0);
    rd(STS);
    cb("stopSeen", v, ihc_pkg::ST_STOPSEEN, 1'b1);
    cb("stopIrq", v, ihc_pkg::ST_SPIRQ, 1'b1);
    cb("stopWcol", v, ihc_pkg::ST_WCOLL, 1'b1);
    wr(STS, 8'h38);
    // Another host starts and stops while our side is idle
    @(posedge clk);
    pullSda <= 1'b1;
    repeat (6) @(posedge clk);
    pullScl <= 1'b1;
    repeat (6) @(posedge clk);
    pullScl <= 1'b0;
    rd(STS);
    cb("startSeen", v, ihc_pkg::ST_STARTSEEN, 1'b1);
    pullSda <= 1'b0;
    repeat (6) @(posedge clk);
    rd(STS);
    cb("busStopSeen", v, ihc_pkg::ST_STOPSEEN, 1'b1);
    cb("busStopIrq", v, ihc_pkg::ST_SPIRQ, 1'b1);
    chk("portIrqOn", 8'(portIrq), 8'h01);
    wr(CTL, 8'h00);
    rd(STS);
    cb("disStop", v, ihc_pkg::ST_STOPSEEN, 1'b0);
    cb("disStart", v, ihc_pkg::ST_STARTSEEN, 1'b0);
    wr(STS, 8'h38);
    wr(CTL, base);
    repeat (2) @(posedge clk);
    #1;
    chk("portIrqOff", 8'(portIrq), 8'h00);
    // Start with SDA already held low by someone else
    @(posedge clk);
    pullSda <= 1'b1;
    wr(CTL, base | b(ihc_pkg::CTL_START));
    repeat (10) @(posedge clk);
    rd(STS);
    cb("startColl", v, ihc_pkg::ST_BCOLL, 1'b1);
    rd(CTL);
    cb("startGo", v, ihc_pkg::CTL_START, 1'b0);
    chk("startLines", 8'({sclOe, sdaOe}), 8'h00);
    chk("collIrq", 8'(portIrq), 8'h01);
    pullSda <= 1'b0;
    wr(STS, 8'h38);
    // Another host pulls SCL low during the first start count
    wr(CTL, base | b(ihc_pkg::CTL_START));
    repeat (3) @(posedge clk);
    pullScl <= 1'b1;
    repeat (8) @(posedge clk);
    pullScl <= 1'b0;
    rd(STS);
    cb("startSclColl", v, ihc_pkg::ST_BCOLL, 1'b1);
    wr(STS, 8'h38);
    wr(CTL, base | b(ihc_pkg::CTL_START));
    wl(1'b1, 1'b1);
    chk("startSclFree", 8'(sclOe), 8'h00);
    wl(1'b0, 1'b1);
    cr("startSclLow", H - 1, H + 2);
    repeat (2) @(posedge clk);
    wr(CTL, base | b(ihc_pkg::CTL_RESTART));
    wl(1'b1, 1'b0);
    wl(1'b0, 1'b0);
    cr("rsScl", H - 1, H + 3);
    wl(1'b1, 1'b1);
    cr("rsSda", H, H + 4);
    wl(1'b0, 1'b1);
    cr("rsEnd", H - 1, H + 2);
    repeat (2) @(posedge clk);
    rd(CTL);
    cb("rsGo", v, ihc_pkg::CTL_RESTART, 1'b0);
    rd(STS);
    cb("rsNoColl", v, ihc_pkg::ST_BCOLL, 1'b0);
    // Restart where SDA is found low once SCL is high
    wr(CTL, base | b(ihc_pkg::CTL_RESTART));
    wl(1'b1, 1'b0);
    pulse_sda_at_scl_release();
    rd(STS);
    cb("rsColl", v, ihc_pkg::ST_BCOLL, 1'b1);
    rd(CTL);
    chk("rsCollGo", v & 8'h0f, 8'h00);
    chk("rsLines", 8'({sclOe, sdaOe}), 8'h00);
    pullSda <= 1'b0;
    wr(STS, 8'h38);
    // Ack of one loses arbitration
    wr(CTL, base | b(ihc_pkg::CTL_ACK) | b(ihc_pkg::CTL_ACKVAL));
    wl(1'b0, 1'b1);
    chk("nackSda", 8'(sdaOe), 8'h00);
    pulse_sda_at_scl_release();
    rd(STS);
    cb("ackColl", v, ihc_pkg::ST_BCOLL, 1'b1);
    rd(CTL);
    cb("ackCollGo", v, ihc_pkg::CTL_ACK, 1'b0);
    chk("ackLines", 8'({sclOe, sdaOe}), 8'h00);
    pullSda <= 1'b0;
    wr(STS, 8'h38);
    // Byte of ones loses arbitration on its first bit
    wr(BUF, 8'hff);
    rd(STS);
    cb("fullSet", v, ihc_pkg::ST_FULL, 1'b1);
    wl(1'b0, 1'b1);
    pulse_sda_at_scl_release();
    rd(STS);
    cb("txColl", v, ihc_pkg::ST_BCOLL, 1'b1);
    cb("txFull", v, ihc_pkg::ST_FULL, 1'b0);
    chk("txLines", 8'({sclOe, sdaOe}), 8'h00);
    pullSda <= 1'b0;
    wr(STS, 8'h38);
    wr(BUF, 8'h7f);
    rd(STS);
    cb("txWritable", v, ihc_pkg::ST_WCOLL, 1'b0);
    wl(1'b1, 1'b1);
    chk("firstBitLow", 8'(sclOe), 8'h01);
    // Nine clocks of about 18 cycles each, no client to acknowledge
    repeat (200) @(posedge clk);
    rd(STS);
    cb("txEmpty", v, ihc_pkg::ST_FULL, 1'b0);
    cb("txNack", v, ihc_pkg::ST_ACKSTAT, 1'b1);
    // Reset while idle, after the byte has finished
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    chk("rstLines", 8'({sclOe, sdaOe}), 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(CTL);
    chk("rstCtrl", v, 8'h00);
    rd(RLD);
    chk("rstReload", v, ihc_pkg::RELOAD_RST);
    close_out();
  end
endmodule
`default_nettype wire
